// ### ada_dma_dev.sv
`timescale 1ns/10ps
`include "ada_defs.svh"
module ada_dma_dev (
    ada_link_if.dev lnk,
    input wire logic mclk,
    input wire logic reset_n,
    output logic [`ADA_NCH-1:0][15:0] tx_data,
    output logic [`ADA_NCH-1:0] tx_valid,
    input wire logic [`ADA_NCH-1:0] tx_ready,
    input wire logic [`ADA_NCH-1:0][15:0] rx_data,
    input wire logic [`ADA_NCH-1:0] rx_valid,
    output logic [`ADA_NCH-1:0] rx_ready,
    input wire logic slot11_sel,
    output logic tx_slot11
);
    localparam int NCH = `ADA_NCH;

    ada_pkg::ada_dec_t dec;
    logic [7:0] cmd_r [NCH];
    logic [1:0] sts_r [NCH];
    logic [31:0] ptr_r [NCH];
    logic mreq [NCH];
    logic mwe [NCH];
    logic [31:0] maddr [NCH];
    logic [3:0] mbe [NCH];
    logic [31:0] mwdat [NCH];
    logic [1:0] own_q, own_d, owner;
    logic busy_q, busy_d;
    logic [31:0] rdata_q, rdata_d;
    logic rvalid_q;
    logic slot_q;

    assign dec = ada_pkg::ada_decode(lnk.reg_addr);

    // ----------------------------------------------------------------
    // per-channel descriptor sequencer
    // ----------------------------------------------------------------
    for (genvar c = 0; c < NCH; c++) begin : g_ch
        ada_pkg::ada_state_t st_q, st_d;
        logic [7:0] cmd_q, cmd_d;
        logic [1:0] sts_q, sts_d;
        logic [31:0] ptr_q, ptr_d, base_q, base_d, wdat_q, wdat_d;
        logic [`ADA_CNT_W-1:0] rem_q, rem_d;
        logic eop_q, eop_d, eot_q, eot_d;
        logic [15:0] txd_q, txd_d;
        logic txv_q, txv_d;
        logic wr_cmd, wr_ptr, rd_sts, ack, hit;

        assign hit = dec.ch == 2'(c);
        assign wr_cmd = lnk.reg_wr && hit && dec.kind == ada_pkg::ADA_K_CMD;
        assign wr_ptr = lnk.reg_wr && hit && dec.kind == ada_pkg::ADA_K_PTR;
        assign rd_sts = lnk.reg_rd && hit && dec.kind == ada_pkg::ADA_K_STS;
        assign ack = lnk.mem_ack && owner == 2'(c);
        assign cmd_r[c] = cmd_q;
        assign sts_r[c] = sts_q;
        assign ptr_r[c] = ptr_q;
        assign tx_data[c] = txd_q;
        assign tx_valid[c] = txv_q;
        assign mwdat[c] = wdat_q;
        // inbound sample taken only while a region has bytes left
        assign rx_ready[c] = st_q == ada_pkg::ADA_XFER && rem_q != '0
            && cmd_q[`ADA_CMD_DIR];

        // next-state and register updates
        always_comb begin
            st_d = st_q;
            cmd_d = cmd_q;
            sts_d = sts_q;
            ptr_d = ptr_q;
            base_d = base_q;
            wdat_d = wdat_q;
            rem_d = rem_q;
            eop_d = eop_q;
            eot_d = eot_q;
            txd_d = txd_q;
            txv_d = txv_q;
            mreq[c] = 1'b0;
            mwe[c] = 1'b0;
            maddr[c] = ptr_q;
            mbe[c] = 4'hf;
            // only enable and direction are stored; rest reads zero
            if (wr_cmd) cmd_d = lnk.reg_wdata[7:0] & `ADA_CMD_MASK;
            if (wr_ptr) ptr_d = lnk.reg_wdata & `ADA_PTR_MASK;
            // a status read clears; sets below still win
            if (rd_sts) sts_d = `ADA_RST_STS;
            case (st_q)
                ada_pkg::ADA_IDLE, ada_pkg::ADA_DONE: begin
                    // pointer register is the first fetch address
                    if (wr_cmd && lnk.reg_wdata[`ADA_CMD_EN])
                        st_d = ada_pkg::ADA_FETCH0;
                end
                ada_pkg::ADA_FETCH0: begin
                    mreq[c] = 1'b1;
                    if (ack) begin
                        base_d = lnk.mem_rdata;
                        st_d = ada_pkg::ADA_FETCH1;
                    end
                end
                ada_pkg::ADA_FETCH1: begin
                    mreq[c] = 1'b1;
                    maddr[c] = ptr_q + `ADA_WORD_STEP;
                    if (ack) begin
                        // register now names the following entry
                        ptr_d = ptr_q + `ADA_PTR_STEP;
                        eot_d = lnk.mem_rdata[`ADA_D_EOT];
                        eop_d = lnk.mem_rdata[`ADA_D_EOP];
                        rem_d = lnk.mem_rdata[`ADA_CNT_W-1:0];
                        if (lnk.mem_rdata[`ADA_D_JMP]) begin
                            ptr_d = base_q & `ADA_PTR_MASK;
                            st_d = ada_pkg::ADA_FETCH0;
                        end else begin
                            st_d = ada_pkg::ADA_XFER;
                        end
                    end
                end
                ada_pkg::ADA_XFER: begin
                    if (rem_q == '0) begin
                        if (eop_q && sts_q[`ADA_STS_EOP] && !rd_sts) begin
                            sts_d[`ADA_STS_ERR] = 1'b1;
                            st_d = ada_pkg::ADA_PAUSE;
                        end else begin
                            if (eop_q) sts_d[`ADA_STS_EOP] = 1'b1;
                            st_d = eot_q ? ada_pkg::ADA_DONE
                                : ada_pkg::ADA_FETCH0;
                        end
                    end else if (!cmd_q[`ADA_CMD_DIR]) begin
                        st_d = ada_pkg::ADA_MRD;
                    end else if (rx_valid[c]) begin
                        wdat_d = {rx_data[c], rx_data[c]};
                        st_d = ada_pkg::ADA_MWR;
                    end
                end
                ada_pkg::ADA_MRD: begin
                    mreq[c] = 1'b1;
                    maddr[c] = base_q & `ADA_PTR_MASK;
                    if (ack) begin
                        txd_d = base_q[1] ? lnk.mem_rdata[31:16]
                            : lnk.mem_rdata[15:0];
                        txv_d = 1'b1;
                        st_d = ada_pkg::ADA_PUSH;
                    end
                end
                ada_pkg::ADA_PUSH: begin
                    if (tx_ready[c]) begin
                        txv_d = 1'b0;
                        base_d = base_q + 32'(`ADA_SAMPLE_BYTES);
                        rem_d = rem_q < `ADA_SAMPLE_BYTES ? '0
                            : rem_q - `ADA_SAMPLE_BYTES;
                        st_d = ada_pkg::ADA_XFER;
                    end
                end
                ada_pkg::ADA_MWR: begin
                    mreq[c] = 1'b1;
                    mwe[c] = 1'b1;
                    maddr[c] = base_q & `ADA_PTR_MASK;
                    mbe[c] = base_q[1] ? `ADA_BE_HI : `ADA_BE_LO;
                    if (ack) begin
                        base_d = base_q + 32'(`ADA_SAMPLE_BYTES);
                        rem_d = rem_q < `ADA_SAMPLE_BYTES ? '0
                            : rem_q - `ADA_SAMPLE_BYTES;
                        st_d = ada_pkg::ADA_XFER;
                    end
                end
                ada_pkg::ADA_PAUSE: begin
                    // the read cleared the first mark; report this one
                    if (rd_sts) begin
                        sts_d[`ADA_STS_EOP] = 1'b1;
                        st_d = eot_q ? ada_pkg::ADA_DONE
                            : ada_pkg::ADA_FETCH0;
                    end
                end
                default: st_d = ada_pkg::ADA_IDLE;
            endcase
            // disable mid-transfer is undefined; we simply drop to idle
            if (wr_cmd && !lnk.reg_wdata[`ADA_CMD_EN]) begin
                st_d = ada_pkg::ADA_IDLE;
                txv_d = 1'b0;
            end
        end

        // registers; everything software sees resets to zero
        always_ff @(posedge mclk or negedge reset_n) begin
            if (!reset_n) begin
                st_q <= ada_pkg::ADA_IDLE;
                cmd_q <= `ADA_RST_CMD;
                sts_q <= `ADA_RST_STS;
                ptr_q <= `ADA_RST_PTR;
                base_q <= '0;
                wdat_q <= '0;
                rem_q <= '0;
                eop_q <= 1'b0;
                eot_q <= 1'b0;
                txd_q <= '0;
                txv_q <= 1'b0;
            end else begin
                st_q <= st_d;
                cmd_q <= cmd_d;
                sts_q <= sts_d;
                ptr_q <= ptr_d;
                base_q <= base_d;
                wdat_q <= wdat_d;
                rem_q <= rem_d;
                eop_q <= eop_d;
                eot_q <= eot_d;
                txd_q <= txd_d;
                txv_q <= txv_d;
            end
        end
    end

    // ----------------------------------------------------------------
    // memory master arbiter and register readback
    // ----------------------------------------------------------------
    // lowest channel wins; grant held until the memory acknowledges
    always_comb begin
        owner = own_q;
        if (!busy_q) begin
            for (int i = NCH - 1; i >= 0; i--) begin
                if (mreq[i]) owner = 2'(i);
            end
        end
        lnk.mem_req = mreq[owner];
        lnk.mem_we = mwe[owner];
        lnk.mem_addr = maddr[owner];
        lnk.mem_be = mbe[owner];
        lnk.mem_wdata = mwdat[owner];
        own_d = owner;
        busy_d = lnk.mem_req && !lnk.mem_ack;
    end

    // unmapped offsets read zero; reserved status bits read zero
    // data holds between reads so a late sampler still sees it
    always_comb begin
        rdata_d = '0;
        if (!lnk.reg_rd)
            rdata_d = rdata_q;
        else if (dec.kind == ada_pkg::ADA_K_CMD)
            rdata_d = {24'h00_0000, cmd_r[dec.ch]};
        else if (dec.kind == ada_pkg::ADA_K_STS)
            rdata_d = {30'h0000_0000, sts_r[dec.ch]};
        else if (dec.kind == ada_pkg::ADA_K_PTR)
            rdata_d = ptr_r[dec.ch];
    end

    assign lnk.reg_rdata = rdata_q;
    assign lnk.reg_rvalid = rvalid_q;
    assign tx_slot11 = slot_q;

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            own_q <= `ADA_CH_O5;
            busy_q <= 1'b0;
            rdata_q <= '0;
            rvalid_q <= 1'b0;
            slot_q <= 1'b0;
        end else begin
            own_q <= own_d;
            busy_q <= busy_d;
            rdata_q <= rdata_d;
            rvalid_q <= lnk.reg_rd;
            slot_q <= slot11_sel;
        end
    end
endmodule : ada_dma_dev

// ### ada_defs.svh
// Function
// - second end-of-page before clear: error, pause
// - status read clears bits, resumes paused channel
// - status bit 0 after end-of-page data moved
// - software loads table pointer before enabling
// - enable loads pointer as first descriptor
// - pointer advances by eight per descriptor
// - pointer reads show next descriptor address
// - software keeps pointer bits 1:0 zero
// - descriptor is two words, first is base
// - bit 31 ends the descriptor table
// - bit 30 marks end-of-page descriptor
// - bit 29 redirects fetching, no data
// - software writes descriptor bits 28:16 zero
// - bits 15:0 give region byte count
// - command bit 3: 0 reads, 1 writes
// - inbound slot 5 channel: direction one
// - reserved command bits written and read zero
// - slot 5 outbound and inbound 16-bit samples
// - fourth channel slot 6 or 11 selected
// - enable bit starts, clearing it disables
// - disable only when paused or table ended
// - fourth channel: direction bit zero
`ifndef ADA_DEFS_SVH
`define ADA_DEFS_SVH
// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define ADA_OFF_CMD_O5 8'h30
`define ADA_OFF_STS_O5 8'h31
`define ADA_OFF_PTR_O5 8'h34
`define ADA_OFF_CMD_I5 8'h38
`define ADA_OFF_STS_I5 8'h39
`define ADA_OFF_PTR_I5 8'h3c
`define ADA_OFF_CMD_O6 8'h40
`define ADA_OFF_STS_O6 8'h41
`define ADA_OFF_PTR_O6 8'h44
// ----------------------------------------------------------------
// fields, masks and steps
// ----------------------------------------------------------------
`define ADA_NCH 3
`define ADA_CH_O5 2'h0
`define ADA_CH_I5 2'h1
`define ADA_CH_O6 2'h2
`define ADA_CMD_EN 0
`define ADA_CMD_DIR 3
`define ADA_CMD_MASK 8'h09
`define ADA_STS_EOP 0
`define ADA_STS_ERR 1
`define ADA_PTR_MASK 32'hffff_fffc
`define ADA_PTR_STEP 32'h0000_0008
`define ADA_WORD_STEP 32'h0000_0004
`define ADA_D_EOT 31
`define ADA_D_EOP 30
`define ADA_D_JMP 29
`define ADA_D_RSV 32'h1fff_0000
`define ADA_CNT_W 16
`define ADA_SAMPLE_BYTES 16'h0002
`define ADA_BE_LO 4'h3
`define ADA_BE_HI 4'hc
`define ADA_RST_CMD 8'h00
`define ADA_RST_STS 2'h0
`define ADA_RST_PTR 32'h0000_0000
`endif

// ### ada_pkg.sv
`include "ada_defs.svh"
package ada_pkg;
    // one-hot channel sequencer states
    typedef enum logic [8:0] {
        ADA_IDLE = 9'h001,
        ADA_FETCH0 = 9'h002,
        ADA_FETCH1 = 9'h004,
        ADA_XFER = 9'h008,
        ADA_MRD = 9'h010,
        ADA_PUSH = 9'h020,
        ADA_MWR = 9'h040,
        ADA_PAUSE = 9'h080,
        ADA_DONE = 9'h100
    } ada_state_t;

    typedef enum logic [1:0] {
        ADA_K_NONE = 2'h0,
        ADA_K_CMD = 2'h1,
        ADA_K_STS = 2'h2,
        ADA_K_PTR = 2'h3
    } ada_kind_t;

    typedef struct packed {
        ada_kind_t kind;
        logic [1:0] ch;
    } ada_dec_t;

    // register offset to channel and register kind
    function automatic ada_dec_t ada_decode(input logic [7:0] a);
        ada_dec_t r;
        r = '{kind: ADA_K_NONE, ch: `ADA_CH_O5};
        if (a == `ADA_OFF_CMD_O5) r = '{ADA_K_CMD, `ADA_CH_O5};
        else if (a == `ADA_OFF_STS_O5) r = '{ADA_K_STS, `ADA_CH_O5};
        else if (a == `ADA_OFF_PTR_O5) r = '{ADA_K_PTR, `ADA_CH_O5};
        else if (a == `ADA_OFF_CMD_I5) r = '{ADA_K_CMD, `ADA_CH_I5};
        else if (a == `ADA_OFF_STS_I5) r = '{ADA_K_STS, `ADA_CH_I5};
        else if (a == `ADA_OFF_PTR_I5) r = '{ADA_K_PTR, `ADA_CH_I5};
        else if (a == `ADA_OFF_CMD_O6) r = '{ADA_K_CMD, `ADA_CH_O6};
        else if (a == `ADA_OFF_STS_O6) r = '{ADA_K_STS, `ADA_CH_O6};
        else if (a == `ADA_OFF_PTR_O6) r = '{ADA_K_PTR, `ADA_CH_O6};
        return r;
    endfunction : ada_decode
endpackage : ada_pkg

// ### ada_link_if.sv
`timescale 1ns/10ps
interface ada_link_if;
    // register port: host issues, device answers next cycle
    logic reg_wr;
    logic reg_rd;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata;
    logic [31:0] reg_rdata;
    logic reg_rvalid;
    // memory port: device is bus master, host is memory
    logic mem_req;
    logic mem_we;
    logic [31:0] mem_addr;
    logic [3:0] mem_be;
    logic [31:0] mem_wdata;
    logic mem_ack;
    logic [31:0] mem_rdata;

    modport dev (
        input reg_wr, reg_rd, reg_addr, reg_wdata,
        output reg_rdata, reg_rvalid,
        output mem_req, mem_we, mem_addr, mem_be, mem_wdata,
        input mem_ack, mem_rdata
    );
    modport host (
        output reg_wr, reg_rd, reg_addr, reg_wdata,
        input reg_rdata, reg_rvalid,
        input mem_req, mem_we, mem_addr, mem_be, mem_wdata,
        output mem_ack, mem_rdata
    );
endinterface : ada_link_if

// ### ada_dma_host.sv
`timescale 1ns/10ps
`include "ada_defs.svh"
module ada_dma_host #(
    parameter int MEM_WORDS = 64
) (
    ada_link_if.host lnk,
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic sw_valid,
    input wire logic sw_write,
    input wire logic [7:0] sw_addr,
    input wire logic [31:0] sw_wdata,
    output logic sw_ready,
    output logic sw_rvalid,
    output logic [31:0] sw_rdata,
    input wire logic ld_valid,
    input wire logic [31:0] ld_addr,
    input wire logic [31:0] ld_data
);
    localparam int AW = $clog2(MEM_WORDS);

    if (MEM_WORDS < 4 || (MEM_WORDS & (MEM_WORDS - 1)) != 0) begin : g_chk
        $error("MEM_WORDS must be a power of two of at least 4");
    end

    ada_pkg::ada_dec_t sdec;
    logic wr_q, rd_q;
    logic [7:0] addr_q;
    logic [31:0] wd_q, wd_d;
    logic [`ADA_NCH-1:0] pset_q, pset_d;
    logic [31:0] mem_q [MEM_WORDS];
    logic [31:0] mem_d [MEM_WORDS];
    logic ack_q, ack_d;
    logic [31:0] mrd_q, mrd_d;
    logic [AW-1:0] widx;

    assign sdec = ada_pkg::ada_decode(sw_addr);
    assign sw_ready = 1'b1;
    assign sw_rvalid = lnk.reg_rvalid;
    assign sw_rdata = lnk.reg_rdata;
    assign lnk.reg_wr = wr_q;
    assign lnk.reg_rd = rd_q;
    assign lnk.reg_addr = addr_q;
    assign lnk.reg_wdata = wd_q;
    assign lnk.mem_ack = ack_q;
    assign lnk.mem_rdata = mrd_q;
    assign widx = lnk.mem_addr[AW+1:2];

    // ----------------------------------------------------------------
    // register writes are made legal before they reach the device
    // ----------------------------------------------------------------
    always_comb begin
        wd_d = sw_wdata;
        pset_d = pset_q;
        if (sw_valid && sw_write && sdec.kind == ada_pkg::ADA_K_PTR) begin
            wd_d = sw_wdata & `ADA_PTR_MASK;
            pset_d[sdec.ch] = 1'b1;
        end
        if (sdec.kind == ada_pkg::ADA_K_CMD) begin
            wd_d = {24'h00_0000, sw_wdata[7:0] & `ADA_CMD_MASK};
            // inbound writes memory, both outbound channels read it
            wd_d[`ADA_CMD_DIR] = sdec.ch == `ADA_CH_I5;
            // no enable until a table pointer has been written
            if (!pset_q[sdec.ch]) wd_d[`ADA_CMD_EN] = 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // memory answering the device's bus-master cycles
    // ----------------------------------------------------------------
    // one wait state: ack follows a request by one cycle, never twice
    always_comb begin
        mem_d = mem_q;
        ack_d = lnk.mem_req && !ack_q;
        mrd_d = mrd_q;
        if (ack_d) begin
            mrd_d = mem_q[widx];
            if (lnk.mem_we) begin
                for (int b = 0; b < 4; b++) begin
                    if (lnk.mem_be[b])
                        mem_d[widx][b*8 +: 8] = lnk.mem_wdata[b*8 +: 8];
                end
            end
        end
        // preload wins; tables are written before channels start
        if (ld_valid) mem_d[ld_addr[AW-1:0]] = ld_data;
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            addr_q <= '0;
            wd_q <= '0;
            pset_q <= '0;
            ack_q <= 1'b0;
            mrd_q <= '0;
            for (int i = 0; i < MEM_WORDS; i++) mem_q[i] <= '0;
        end else begin
            wr_q <= sw_valid && sw_write;
            rd_q <= sw_valid && !sw_write;
            addr_q <= sw_addr;
            wd_q <= wd_d;
            pset_q <= pset_d;
            ack_q <= ack_d;
            mrd_q <= mrd_d;
            mem_q <= mem_d;
        end
    end
endmodule : ada_dma_host

// ### ada_dma_checker.sv
`timescale 1ns/10ps
// --------
// link checks: register answers and memory handshake
// --------
module ada_dma_checker (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_rdata,
    input wire logic reg_rvalid,
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [31:0] mem_addr,
    input wire logic [3:0] mem_be,
    input wire logic [31:0] mem_wdata,
    input wire logic mem_ack
);
    // one clock domain, so clocking and reset are shared
    default clocking dc @(posedge mclk);
    endclocking
    default disable iff (!reset_n);

    rd_answer_a: assert property (
        reg_rd |=> reg_rvalid)
        else $error("register read not answered next cycle");
    no_spur_ans_a: assert property (
        reg_rvalid |-> $past(reg_rd))
        else $error("register answer without a read");
    sts_rsvd_zero_a: assert property (
        reg_rd && reg_addr[2:0] == 3'h1 |=> reg_rdata[31:2] == 30'h0)
        else $error("reserved status bits not zero");
    cmd_rsvd_zero_a: assert property (
        reg_rd && reg_addr[2:0] == 3'h0
        |=> reg_rdata[31:4] == 28'h0 && reg_rdata[2:1] == 2'h0)
        else $error("reserved command bits not zero");
    ptr_align_a: assert property (
        reg_rd && reg_addr[2:0] == 3'h4 |=> reg_rdata[1:0] == 2'h0)
        else $error("pointer read not word aligned");
    req_hold_a: assert property (
        mem_req && !mem_ack |=> mem_req && $stable(mem_addr)
        && $stable(mem_we) && $stable(mem_be))
        else $error("memory request changed before ack");
    ack_prompt_a: assert property (
        $rose(mem_req) |=> mem_ack)
        else $error("memory ack late");
    ack_pulse_a: assert property (
        mem_ack |-> mem_req ##1 !mem_ack)
        else $error("memory ack not a single pulse");
    wr_half_a: assert property (
        mem_req && mem_we |-> (mem_be == 4'h3 || mem_be == 4'hc)
        && mem_wdata[31:16] == mem_wdata[15:0])
        else $error("sample write not a 16-bit half");
    rd_full_a: assert property (
        mem_req && !mem_we |-> mem_be == 4'hf && mem_addr[1:0] == 2'h0)
        else $error("memory read malformed");
endmodule : ada_dma_checker

// ### ada_dma_tb_top.sv
`timescale 1ns/10ps
`include "ada_defs.svh"
// --------
// bench: software port drives both ends
// --------
module ada_dma_tb_top;
    logic mclk, reset_n, sw_valid, sw_write, sw_ready, sw_rvalid;
    logic ld_valid, slot11_sel, tx_slot11;
    logic [7:0] sw_addr;
    logic [31:0] sw_wdata, sw_rdata, ld_addr, ld_data, wr_addr, wr_data;
    logic [3:0] wr_be;
    logic [`ADA_NCH-1:0][15:0] tx_data, rx_data;
    logic [`ADA_NCH-1:0] tx_valid, tx_ready, rx_valid, rx_ready;
    logic [15:0] got0 [$];
    logic [7:0] offs [10] = '{8'h30, 8'h31, 8'h34, 8'h38, 8'h39,
        8'h3c, 8'h40, 8'h41, 8'h44, 8'h32};
    int fails = 0;
    int comparisons = 0;
    int tx_cnt [4] = '{0, 0, 0, 0};

    ada_link_if lnk ();
    ada_dma_dev ada_dma_dev_i (.lnk(lnk), .mclk(mclk), .reset_n(reset_n),
        .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
        .slot11_sel(slot11_sel), .tx_slot11(tx_slot11));
    ada_dma_host #(.MEM_WORDS(64)) ada_dma_host_i (.lnk(lnk), .mclk(mclk),
        .reset_n(reset_n), .sw_valid(sw_valid), .sw_write(sw_write),
        .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_ready(sw_ready),
        .sw_rvalid(sw_rvalid), .sw_rdata(sw_rdata), .ld_valid(ld_valid),
        .ld_addr(ld_addr), .ld_data(ld_data));
    ada_dma_checker ada_dma_checker_i (.mclk(mclk), .reset_n(reset_n),
        .reg_rd(lnk.reg_rd), .reg_addr(lnk.reg_addr),
        .reg_rdata(lnk.reg_rdata), .reg_rvalid(lnk.reg_rvalid),
        .mem_req(lnk.mem_req), .mem_we(lnk.mem_we),
        .mem_addr(lnk.mem_addr), .mem_be(lnk.mem_be),
        .mem_wdata(lnk.mem_wdata), .mem_ack(lnk.mem_ack));

    // 250 MHz clock
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    // tally samples leaving and memory writes; slot 3 counts writes
    always @(posedge mclk) begin
        for (int c = 0; c < 3; c++) begin
            if (tx_valid[c] === 1'b1 && tx_ready[c] === 1'b1) begin
                tx_cnt[c]++;
                if (c == 0) got0.push_back(tx_data[0]);
            end
        end
        if (lnk.mem_ack === 1'b1 && lnk.mem_we === 1'b1) begin
            tx_cnt[3]++;
            wr_addr = lnk.mem_addr;
            wr_data = lnk.mem_wdata;
            wr_be = lnk.mem_be;
        end
    end

    // --------
    // tasks
    // --------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask : check

    task automatic stall();
        fails++;
        $display("unexpected at %0t: wait ran out", $time);
        report_and_stop();
    endtask : stall

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        sw_valid <= 1'b1;
        sw_write <= 1'b1;
        sw_addr <= a;
        sw_wdata <= d;
        @(posedge mclk);
        sw_valid <= 1'b0;
    endtask : wr

    // read one register and compare; answer is never back-pressured
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        int n;
        @(posedge mclk);
        sw_valid <= 1'b1;
        sw_write <= 1'b0;
        sw_addr <= a;
        @(posedge mclk);
        sw_valid <= 1'b0;
        n = 0;
        while (sw_rvalid !== 1'b1 && n < 8) begin
            @(posedge mclk);
            n++;
        end
        if (n == 8) stall();
        check(sw_rdata, e);
    endtask : rd

    task automatic ld(input logic [31:0] w, input logic [31:0] d);
        @(posedge mclk);
        ld_valid <= 1'b1;
        ld_addr <= w;
        ld_data <= d;
        @(posedge mclk);
        ld_valid <= 1'b0;
    endtask : ld

    // bounded wait on a tally; a stuck channel ends the run
    task automatic waitfor(input int c, input int k);
        int n;
        n = 0;
        while (tx_cnt[c] < k && n < 400) begin
            @(posedge mclk);
            n++;
        end
        if (n == 400) stall();
    endtask : waitfor

    task automatic report_and_stop();
        $display("comparisons %0d, fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : report_and_stop

    // --------
    // main sequence
    // --------
    initial begin
        {sw_valid, sw_write, ld_valid, slot11_sel, reset_n} = 5'h0;
        sw_addr = 8'h0;
        {sw_wdata, ld_addr, ld_data} = 96'h0;
        tx_ready = 3'h7;
        rx_valid = 3'h0;
        rx_data = 48'h0;
        repeat (6) @(posedge mclk);
        reset_n <= 1'b1;
        foreach (offs[i]) rd(offs[i], 32'h0);
        // tables: ch0 at 0x40, ch2 at 0x00, ch1 jump at 0x20
        ld(16, 32'h0000_0080);
        ld(17, 32'hc000_0004);
        ld(32, 32'hbbbb_aaaa);
        ld(0, 32'h0000_0080);
        ld(1, 32'h4000_0002);
        ld(2, 32'h0000_0080);
        ld(3, 32'hc000_0002);
        ld(8, 32'h0000_0030);
        ld(9, 32'h2000_0000);
        ld(12, 32'h0000_00c0);
        ld(13, 32'h8000_0002);
        // enable without a pointer is dropped, reserved bits vanish
        wr(8'h38, 32'h0000_00ff);
        rd(8'h38, 32'h0000_0008);
        // outbound slot 5: one word split into two samples
        wr(8'h34, 32'h0000_0043);
        rd(8'h34, 32'h0000_0040);
        wr(8'h30, 32'h0000_0001);
        waitfor(0, 2);
        check({16'h0, got0[0]}, 32'h0000_aaaa);
        check({16'h0, got0[1]}, 32'h0000_bbbb);
        rd(8'h34, 32'h0000_0048);
        rd(8'h31, 32'h0000_0001);
        rd(8'h31, 32'h0000_0000);
        // disable only once the table has ended
        wr(8'h30, 32'h0000_0000);
        rd(8'h30, 32'h0000_0000);
        // fourth channel: second mark before clearing pauses it
        slot11_sel <= 1'b1;
        wr(8'h44, 32'h0000_0000);
        wr(8'h40, 32'h0000_0001);
        waitfor(2, 2);
        repeat (20) @(posedge mclk);
        check({31'h0, tx_slot11}, 32'h0000_0001);
        rd(8'h44, 32'h0000_0010);
        rd(8'h41, 32'h0000_0003);
        repeat (20) @(posedge mclk);
        rd(8'h41, 32'h0000_0001);
        rd(8'h41, 32'h0000_0000);
        check(tx_cnt[2], 32'h0000_0002);
        check({16'h0, tx_data[2]}, 32'h0000_aaaa);
        rd(8'h44, 32'h0000_0010);
        // inbound slot 5 reached through a jump entry
        rx_data[1] <= 16'h5a5a;
        rx_valid[1] <= 1'b1;
        wr(8'h3c, 32'h0000_0020);
        wr(8'h38, 32'h0000_0009);
        rd(8'h38, 32'h0000_0009);
        waitfor(3, 1);
        repeat (20) @(posedge mclk);
        check(wr_addr, 32'h0000_00c0);
        check(wr_data, 32'h5a5a_5a5a);
        check({28'h0, wr_be}, 32'h0000_0003);
        check(tx_cnt[3], 32'h0000_0001);
        rd(8'h3c, 32'h0000_0038);
        rd(8'h39, 32'h0000_0000);
        check({31'h0, rx_ready[1]}, 32'h0000_0000);
        report_and_stop();
    end
endmodule : ada_dma_tb_top
